// *** cpu_core_model.sv ***
// Purpose: processor core issuing register and table writes
// Assumes: drives at the falling edge
// Notes: key writes kept with no other write between them
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    input  wire logic        clk, cpu_stall,
    input  wire logic [15:0] reg_rdata,
    output var  logic        reg_wr, reg_rd, tlo, thi,
    output var  logic [7:0]  page,
    output var  logic [15:0] reg_addr, reg_wdata, ea, tdata
);
    initial {reg_wr, reg_rd, tlo, thi, page, reg_addr, reg_wdata, ea, tdata} = '0;
    task wr(input [15:0] a, d);
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task rd(input [15:0] a, output [15:0] d);
        @(negedge clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    task tw(input hi, input [15:0] a, d);
        @(negedge clk);
        {tlo, thi, ea, tdata} = {!hi, hi, a, d};
        @(negedge clk);
        {tlo, thi} = 2'h0;
    endtask
    task go(input [15:0] ctl, output int n);
        wr(16'h0766, 16'h0055);
        wr(16'h0766, 16'h00AA);
        wr(16'h0260, ctl);
        repeat (2) @(negedge clk);
        for (n = 0; cpu_stall && n < 500; n++) @(negedge clk);
    endtask
endmodule // cpu_core_model
`default_nettype wire

// *** flash_seq_chk_sva.sv ***
// Purpose: port checker for the flash row sequencer
// Assumes: PROG_CYCLES of 33 or more
// Notes: key state is rebuilt from the write strobes
`timescale 1ns/1ps
`default_nettype none
module flash_seq_chk #(parameter PROG_CYCLES = 64) (
    input wire logic        clk, sys_rst, reg_wr,
    input wire logic        table_write_low_word, table_write_high_byte,
    input wire logic [15:0] reg_addr, reg_wdata,
    input wire logic        cpu_stall, array_erase, array_program,
    input wire logic [23:0] array_addr
);
    logic [1:0]  key_q;
    logic        perm_q;
    logic [31:0] cnt_q;
    wire         kw = reg_wr && reg_addr == 16'h0766;
    wire         cw = reg_wr && reg_addr == 16'h0260;
    wire         anyw = reg_wr || table_write_low_word || table_write_high_byte;
    always_ff @(posedge clk) begin
        cnt_q  <= (sys_rst || !cpu_stall) ? 32'h0 : cnt_q + 32'h1;
        perm_q <= sys_rst ? 1'b0 : (cw && !cpu_stall) ? reg_wdata[14] : perm_q;
        // any other write in between relocks, so track all strobes
        key_q  <= sys_rst ? 2'h0 : (kw && reg_wdata == 16'h0055) ? 2'h1
                : (kw && reg_wdata == 16'h00AA && key_q == 2'h1) ? 2'h2
                : anyw ? 2'h0 : key_q;
    end
    sequence s_start;
        cw && reg_wdata[15] && key_q == 2'h2 && perm_q && !cpu_stall;
    endsequence
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_start_taken: assert property (s_start |=> cpu_stall)
        else $error("start not taken");
    a_start_refused: assert property (
        cw && reg_wdata[15] && key_q != 2'h2 && !cpu_stall |=> !cpu_stall)
        else $error("start not refused");
    a_stall_span: assert property (
        $fell(cpu_stall) |-> cnt_q == PROG_CYCLES) else $error("stall span");
    a_erase_pulse: assert property (
        s_start ##0 reg_wdata[6] |=> ##1 array_erase ##1 !array_erase)
        else $error("erase pulse");
    a_erase_only: assert property (
        s_start ##0 reg_wdata[6] |=> !array_program [*8]) else $error("erase");
    a_row_base: assert property (
        array_erase || array_program |-> array_addr[6:0] == 7'h00)
        else $error("row base");
    a_prog_span: assert property (
        s_start ##0 !reg_wdata[6] |=> ##1 array_program ##32 !array_program)
        else $error("program span");
    a_pulse_stalled: assert property (
        array_erase || array_program |-> cpu_stall) else $error("no stall");
endmodule // flash_seq_chk
bind program_flash_row_sequencer flash_seq_chk #(.PROG_CYCLES(PROG_CYCLES))
    u_chk (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .table_write_low_word(table_write_low_word), .reg_addr(reg_addr),
    .table_write_high_byte(table_write_high_byte), .reg_wdata(reg_wdata),
    .cpu_stall(cpu_stall), .array_erase(array_erase),
    .array_program(array_program), .array_addr(array_addr));
`default_nettype wire

// *** nvm_seq_map.vh ***
// Purpose: constants for the program flash row sequencer
// Assumes: 16-bit special function register port, word addresses as printed
// Notes: none
// How it works
// R1: erase clears one whole 32-word row chosen by captured address.
// R2: write latches hold 96 bytes, 32 words of 24 bits, before programming.
// R3: four low-word and four high-byte table writes fill a group; pointer picks latch.
// R4: high-byte table write keeps only source low byte into latch bits 23:16.
// R5: start refused unless key got 0x55 then 0xAA right before start bit.
// R6: software waits out full programming time before treating it finished.
// R7: software places two no-operations after the start instruction.
// R8: software defers interrupts below priority 7 for 5 instructions around unlock.
// R9: start bit 15 begins operation, stalls cpu, hardware clears it at end.
// R10: address registers capture table instruction address bits 15:0 and 23:16.
// R11: key register is write-only and reads back as zero.
// R12: any wrong key write returns the unlock tracker to locked.
`ifndef NVM_SEQ_MAP_VH
`define NVM_SEQ_MAP_VH
`define NVM_CONTROL_ADDR       16'h0260
`define NVM_ADDRESS_LOW_ADDR   16'h0762
`define NVM_ADDRESS_UPPER_ADDR 16'h0764
`define NVM_UNLOCK_KEY_ADDR    16'h0766
`define NVM_CONTROL_RESET      16'h0000
`define CTL_START_BIT          15
`define CTL_PERMIT_BIT         14
`define CTL_ERR_BIT            13
`define CTL_TIMED_WRITE_SELECT_BIT           8
`define CTL_OP_MSB             6
`define KEY_FIRST              8'h55
`define KEY_SECOND             8'hAA
`define PROG_TIME_US           2000
`define CLK_MHZ                100
`define PROG_CYCLES            (`PROG_TIME_US * `CLK_MHZ)
`define ROW_WORDS              32
`endif

// *** nvm_write_latches.v ***
// Purpose: bank of 24-bit program flash write latches
// Assumes: one table write per cycle at most
// Notes: low word and high byte are written separately
`timescale 1ns/1ps
`default_nettype none
module nvm_write_latches #(
    parameter WORDS = 32,
    parameter AW    = 5
) (
    input  wire          clk,
    input  wire          wr_low,
    input  wire          wr_high,
    input  wire [AW-1:0] idx,
    input  wire [15:0]   wdata,
    input  wire [AW-1:0] rd_idx,
    output wire [23:0]   rd_word
);
    reg [23:0] lat_q [0:WORDS-1]; // [R2]
    always @(posedge clk) begin
        if (wr_low)
            lat_q[idx][15:0] <= wdata; // [R3]
        if (wr_high)
            lat_q[idx][23:16] <= wdata[7:0]; // upper byte dropped [R4]
    end
    assign rd_word = lat_q[rd_idx];
endmodule // nvm_write_latches
`default_nettype wire

// *** program_flash_row_sequencer.v ***
// Purpose: self-programming sequencer: unlock, start, stall, row erase/program
// Assumes: cpu register port synchronous to clk, one access per cycle
// Notes: array is outside; this block drives its row address and strobes
`timescale 1ns/1ps
`default_nettype none
`include "nvm_seq_map.vh"
module program_flash_row_sequencer #(
    parameter PROG_CYCLES = `PROG_CYCLES,
    parameter ROW_WORDS   = `ROW_WORDS
) (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [15:0] reg_addr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    input  wire        table_write_low_word,
    input  wire        table_write_high_byte,
    input  wire [7:0]  table_page_register,
    input  wire [15:0] tbl_ea,
    input  wire [15:0] tbl_wdata,
    output reg         cpu_stall,
    output reg         array_erase,
    output reg         array_program,
    output reg  [23:0] array_addr,
    output reg  [4:0]  array_word_idx,
    output reg  [23:0] array_wdata
);
    localparam S_IDLE = 3'b001;
    localparam S_ERASE = 3'b010;
    localparam S_PROG = 3'b100;
    localparam K_LOCK = 3'b001;
    localparam K_HALF = 3'b010;
    localparam K_OPEN = 3'b100;

    reg  [2:0]  state_q;
    reg  [2:0]  key_q;
    reg  [31:0] cnt_q;
    reg         start_q;
    reg         permit_q;
    reg         err_q;
    reg         timed_write_select_q;
    reg  [6:0]  op_q;
    reg  [15:0] adr_lo_q;
    reg  [7:0]  adr_hi_q;
    reg  [4:0]  widx_q;
    wire [23:0] lat_word;
    wire        sel_ctl = reg_addr == `NVM_CONTROL_ADDR;
    wire        sel_lo  = reg_addr == `NVM_ADDRESS_LOW_ADDR;
    wire        sel_hi  = reg_addr == `NVM_ADDRESS_UPPER_ADDR;
    wire        sel_key = reg_addr == `NVM_UNLOCK_KEY_ADDR;
    wire        tbl_any = table_write_low_word | table_write_high_byte;
    wire        idle    = (state_q == S_IDLE);
    wire        go_req  = reg_wr & sel_ctl & reg_wdata[`CTL_START_BIT];
    // permit must already be set; same-write permit does not count
    wire        go      = go_req & (key_q == K_OPEN) & permit_q
                          & idle; // [R5]
    wire        erase_op = op_q[`CTL_OP_MSB];
    wire [31:0] last_cnt = PROG_CYCLES - 1;
    wire        done    = (cnt_q == last_cnt);
    // row base: low seven bits dropped so the whole row is addressed
    wire [23:0] row_base = {adr_hi_q, adr_lo_q[15:7], 7'h00}; // [R1]
    wire [15:0] ctl_view = {start_q, permit_q, err_q, 4'h0, timed_write_select_q,
                            1'b0, op_q};

    nvm_write_latches #(.WORDS(ROW_WORDS), .AW(5)) u_lat (
        .clk     (clk),
        .wr_low  (table_write_low_word),
        .wr_high (table_write_high_byte),
        .idx     (tbl_ea[6:2]),
        .wdata   (tbl_wdata),
        .rd_idx  (widx_q),
        .rd_word (lat_word)
    );

    // unlock tracker: any other write relocks it, so the two keys
    // must sit directly before the start write
    always @(posedge clk) begin
        if (sys_rst) begin
            key_q <= K_LOCK;
        end else if (reg_wr & sel_key) begin
            if (reg_wdata[7:0] == `KEY_FIRST) begin
                key_q <= K_HALF; // [R5]
            end else if (key_q == K_HALF
                         && reg_wdata[7:0] == `KEY_SECOND) begin
                key_q <= K_OPEN; // [R5]
            end else begin
                key_q <= K_LOCK; // [R12]
            end
        end else if (reg_wr | tbl_any) begin
            key_q <= K_LOCK; // keys must sit right before start [R5]
        end
    end

    // control fields are frozen while an operation runs
    always @(posedge clk) begin
        if (sys_rst) begin
            permit_q <= 1'b0;
            err_q    <= 1'b0;
            timed_write_select_q   <= 1'b0;
            op_q     <= 7'h00;
        end else if (reg_wr & sel_ctl & idle) begin
            permit_q <= reg_wdata[`CTL_PERMIT_BIT];
            // error flag can only be cleared; this block never sets it
            err_q    <= reg_wdata[`CTL_ERR_BIT] & err_q;
            timed_write_select_q   <= reg_wdata[`CTL_TIMED_WRITE_SELECT_BIT];
            op_q     <= reg_wdata[6:0];
        end
    end

    // address capture; a table write wins over a register write
    always @(posedge clk) begin
        if (sys_rst) begin
            adr_lo_q <= 16'h0000;
            adr_hi_q <= 8'h00;
        end else if (idle) begin
            if (tbl_any) begin
                adr_lo_q <= tbl_ea; // [R10]
                adr_hi_q <= table_page_register; // [R10]
            end else if (reg_wr & sel_lo) begin
                adr_lo_q <= reg_wdata;
            end else if (reg_wr & sel_hi) begin
                adr_hi_q <= reg_wdata[7:0];
            end
        end
    end

    // operation sequencer; the cpu is held for the full time
    always @(posedge clk) begin
        if (sys_rst) begin
            state_q        <= S_IDLE;
            cnt_q          <= 32'h0000_0000;
            start_q        <= 1'b0;
            widx_q         <= 5'h00;
            cpu_stall      <= 1'b0;
            array_erase    <= 1'b0;
            array_program  <= 1'b0;
            array_addr     <= 24'h00_0000;
            array_word_idx <= 5'h00;
            array_wdata    <= 24'h00_0000;
        end else begin
            array_erase   <= 1'b0;
            array_program <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (go) begin
                        start_q    <= 1'b1; // [R9]
                        cpu_stall  <= 1'b1; // [R9]
                        cnt_q      <= 32'h0000_0000;
                        widx_q     <= 5'h00;
                        array_addr <= row_base; // [R1]
                        if (erase_op) begin
                            state_q <= S_ERASE;
                        end else begin
                            state_q <= S_PROG;
                        end
                    end
                end
                S_ERASE: begin
                    if (cnt_q == 32'h0000_0000) begin
                        array_erase <= 1'b1; // whole row at once [R1]
                    end
                    cnt_q <= cnt_q + 32'h0000_0001;
                    if (done) begin
                        start_q   <= 1'b0; // [R9]
                        cpu_stall <= 1'b0;
                        state_q   <= S_IDLE;
                    end
                end
                S_PROG: begin
                    // one word per cycle; the array is assumed to keep up
                    if (cnt_q < ROW_WORDS) begin
                        array_program  <= 1'b1; // [R2]
                        array_word_idx <= widx_q;
                        array_wdata    <= lat_word;
                        widx_q         <= widx_q + 5'h01;
                    end
                    cnt_q <= cnt_q + 32'h0000_0001;
                    if (done) begin
                        start_q   <= 1'b0; // [R9]
                        cpu_stall <= 1'b0;
                        state_q   <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // read port; the key register never echoes what was written
    always @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd & sel_ctl) begin
            reg_rdata <= ctl_view;
        end else if (reg_rd & sel_lo) begin
            reg_rdata <= adr_lo_q;
        end else if (reg_rd & sel_hi) begin
            reg_rdata <= {8'h00, adr_hi_q};
        end else begin
            reg_rdata <= 16'h0000; // key reads give zero [R11]
        end
    end
endmodule // program_flash_row_sequencer
`default_nettype wire

// *** program_flash_row_sequencer_bench.sv ***
// Purpose: self-checking bench for the flash row sequencer
// Assumes: short program time of 64 cycles
// Notes: latch contents are seen only through the program pulses
`timescale 1ns/1ps
`default_nettype none
module program_flash_row_sequencer_bench;
    logic        clk = 1'b0, sys_rst = 1'b1;
    logic        cpu_stall, array_erase, array_program, reg_wr, reg_rd, tlo, thi;
    logic [4:0]  widx;
    logic [7:0]  page;
    logic [15:0] reg_addr, reg_wdata, ea, tdata, reg_rdata, v;
    logic [23:0] array_addr, array_wdata;
    int          fails = 0, n_tests = 0, cyc = 0, n_prog = 0, n_er = 0, n;
    program_flash_row_sequencer #(.PROG_CYCLES(64)) u_dut (.clk(clk),
        .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .table_write_low_word(tlo), .table_write_high_byte(thi),
        .table_page_register(page), .tbl_ea(ea), .tbl_wdata(tdata),
        .cpu_stall(cpu_stall), .array_erase(array_erase),
        .array_program(array_program), .array_addr(array_addr),
        .array_word_idx(widx), .array_wdata(array_wdata));
    cpu_core_model u_cpu (.clk(clk), .cpu_stall(cpu_stall), .reg_rdata(reg_rdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .tlo(tlo), .thi(thi), .page(page),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .ea(ea), .tdata(tdata));
    initial forever #5 clk = ~clk;
    task chk(string s, logic [23:0] e, g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    always @(negedge clk) begin
        n_er += array_erase;
        n_prog += array_program;
        if (array_program) chk("latch", {3'h0, widx, widx + 16'h1000}, array_wdata);
        if (array_program || array_erase) chk("row", 24'h01_6000, array_addr);
    end
    task summarize;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) if (++cyc == 5000) begin
        fails++;
        summarize();
    end
    task t_refuse;
        u_cpu.wr(16'h0260, 16'h4000);
        u_cpu.rd(16'h0766, v);
        chk("key read", 24'h0, {8'h00, v});
        u_cpu.wr(16'h0766, 16'h0055);
        u_cpu.wr(16'h0766, 16'h0033);
        u_cpu.wr(16'h0766, 16'h00AA);
        u_cpu.wr(16'h0260, 16'hC000);
        chk("bad key stall", 24'h0, {23'h0, cpu_stall});
    endtask
    task t_prog;
        u_cpu.page = 8'h01;
        for (int i = 0; i < 32; i++) begin
            u_cpu.tw(1'b0, 16'h6000 + 16'(i * 4), 16'h1000 + 16'(i));
            u_cpu.tw(1'b1, 16'h6000 + 16'(i * 4), 16'hA500 + 16'(i));
        end
        u_cpu.rd(16'h0762, v);
        chk("addr low", 24'h00_607C, {8'h00, v});
        u_cpu.rd(16'h0764, v);
        chk("addr upper", 24'h00_0001, {8'h00, v});
        u_cpu.go(16'hC000, n);
        chk("stall cycles", 24'h00_003E, 24'(n));
        chk("pulses", 24'h00_0020, 24'(n_prog));
        u_cpu.rd(16'h0260, v);
        chk("control", 24'h00_4000, {8'h00, v});
    endtask
    task t_erase;
        u_cpu.wr(16'h0260, 16'h4040);
        u_cpu.go(16'hC040, n);
        chk("erase stall", 24'h00_003E, 24'(n));
        chk("erases", 24'h00_0001, 24'(n_er));
    endtask
    task t_reset;
        u_cpu.wr(16'h0762, 16'h1234);
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        u_cpu.rd(16'h0762, v);
        chk("reset addr", 24'h00_0000, {8'h00, v});
        u_cpu.rd(16'h0260, v);
        chk("reset control", 24'h00_0000, {8'h00, v});
        chk("reset stall", 24'h00_0000, {23'h0, cpu_stall});
    endtask
    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        t_refuse();
        t_prog();
        t_erase();
        t_reset();
        summarize();
    end
endmodule // program_flash_row_sequencer_bench
`default_nettype wire
